// File: rtl/relay_map_params.svh
// Purpose: Constants for the relay output process-data map
// Assumes: 125 MHz ref_clk
// Notes:   Offsets are register-space addresses as the master sends them
`ifndef RELAY_MAP_PARAMS_SVH
`define RELAY_MAP_PARAMS_SVH
`define CLK_PERIOD_PS        8000
`define FC_READ_COILS        8'h01
`define FC_READ_HOLD         8'h03
`define FC_READ_DISCRETE     8'h02
`define FC_READ_INPUT        8'h04
`define FC_WRITE_COIL        8'h05
`define FC_WRITE_REG         8'h06
`define FC_WRITE_COILS       8'h0f
`define FC_WRITE_REGS        8'h10
`define DIR_STAT_BITS_BASE   16'h0800
`define ALT_STAT_BITS_BASE   16'h36b1
`define DIR_STAT_WORD_BASE   16'h0300
`define ALT_STAT_WORD_BASE   16'h8980
`define DIR_TYPE_WORD_BASE   16'h0400
`define ALT_TYPE_WORD_BASE   16'h89e4
`define DIR_SLOT_COIL_BASE   16'h0400
`define ALT_SLOT_COIL_BASE   16'h0bb9
`define DIR_ALLOC_COIL_BASE  16'h0000
`define ALT_ALLOC_COIL_BASE  16'h0001
`define DIR_HOLD_BASE        16'h0500
`define ALT_HOLD_BASE        16'hb415
`define OUT_CHAN_MASK        8'h03
`define XCHG_PERIOD_NS       6500
`define XCHG_CYCLES          ((`XCHG_PERIOD_NS * 1000) / `CLK_PERIOD_PS)
`define WDOG_TIME_MS         500
`define WDOG_CYCLES          ((`WDOG_TIME_MS * 1000000) / \
                              (`CLK_PERIOD_PS / 1000))
`define WDOG_FAIL_LIMIT      2'd3
`endif

// File: rtl/relay_map_pkg.sv
// Purpose: Types for the relay output process-data map
// Assumes: Nothing
// Notes:   Request and answer travel as packed structs
package relay_map_pkg;
    typedef struct packed {
        logic        valid;
        logic        alt;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] data;
    } req_t;
    typedef struct packed {
        logic        valid;
        logic        error;
        logic [15:0] data;
    } rsp_t;
endpackage

// File: rtl/relay_output_modbus_map.sv
// Purpose: Relay output module map answering master requests, with watchdog
// Assumes: Com unit decodes frames into single-item requests
// Notes:   Multi-item codes are applied one item per request
//          A com unit that never answers is not counted as a failure
`timescale 1ns/1ps
`default_nettype none
`include "relay_map_params.svh"
module relay_output_modbus_map #(
    parameter int unsigned WDOG_CYC = `WDOG_CYCLES
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    // Master request and answer
    input  wire relay_map_pkg::req_t  req,
    output relay_map_pkg::rsp_t       rsp,
    // Slot of this module and its words
    input  wire logic [7:0]           slot,
    input  wire logic [15:0]          module_status,
    input  wire logic [15:0]          module_type,
    // Com unit exchange
    output logic                      xchg_start,
    input  wire logic                 xchg_done,
    input  wire logic                 xchg_ok,
    // Relay drive
    output logic [1:0]                relay_out,
    output logic                      wdog_trip
);
    localparam int unsigned XCHG_CYC = `XCHG_CYCLES;

    function automatic logic [15:0] bit_addr(input logic [15:0] base,
                                             input logic [7:0]  slt,
                                             input logic [2:0]  bitn);
        bit_addr = 16'(base + {5'h00, slt, 3'h0} + {13'h0000, bitn});
    endfunction

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] base);
        hit = (a >= base) && (a < 16'(base + 16'h0008));
    endfunction

    relay_map_pkg::rsp_t rsp_r, rsp_nxt;
    logic [7:0]  out_byte_r, out_byte_nxt;
    logic [19:0] xchg_cnt_r, xchg_cnt_nxt;
    logic [1:0]  fail_cnt_r, fail_cnt_nxt;
    logic [26:0] wd_cnt_r, wd_cnt_nxt;
    logic        trip_r, trip_nxt;
    logic        busy_r, busy_nxt;
    logic [2:0]  xd_r;

    // Slot bases: bit tables give bit 0 at table base plus eight per slot; status and type words at base plus slot
    logic [15:0] sb_base, sc_base, ac_base, hr_base, sw_addr, tw_addr;
    logic [15:0] bit_off;
    logic [2:0]  idx;

    always_comb
    begin
        sb_base = bit_addr(req.alt ? `ALT_STAT_BITS_BASE : `DIR_STAT_BITS_BASE,
                           slot, 3'h0);
        sc_base = bit_addr(req.alt ? `ALT_SLOT_COIL_BASE : `DIR_SLOT_COIL_BASE,
                           slot, 3'h0);
        ac_base = req.alt ? `ALT_ALLOC_COIL_BASE : `DIR_ALLOC_COIL_BASE;
        hr_base = req.alt ? `ALT_HOLD_BASE : `DIR_HOLD_BASE;
        sw_addr = 16'((req.alt ? `ALT_STAT_WORD_BASE : `DIR_STAT_WORD_BASE)
                      + {8'h00, slot});
        tw_addr = 16'((req.alt ? `ALT_TYPE_WORD_BASE : `DIR_TYPE_WORD_BASE)
                      + {8'h00, slot});
        bit_off = 16'h0000;
        idx     = 3'h0;
        rsp_nxt = '0;
        out_byte_nxt = out_byte_r;
        if (req.valid)
        begin
            rsp_nxt.valid = 1'b1;
            case (req.func)
                `FC_READ_DISCRETE:
                begin
                    if (hit(req.addr, sb_base))
                    begin
                        bit_off = 16'(req.addr - sb_base);
                        idx = bit_off[2:0];
                        rsp_nxt.data = {15'h0000, module_status[4'(8 + idx)]};
                    end
                    else
                        rsp_nxt.error = 1'b1;
                end
                `FC_READ_INPUT:
                begin
                    if (req.addr == sw_addr)
                        rsp_nxt.data = module_status;
                    else if (req.addr == tw_addr)
                        rsp_nxt.data = module_type;
                    else
                        rsp_nxt.error = 1'b1;
                end
                `FC_READ_COILS, `FC_WRITE_COIL, `FC_WRITE_COILS:
                begin
                    if (hit(req.addr, sc_base))
                        bit_off = 16'(req.addr - sc_base);
                    else if (hit(req.addr, ac_base))
                        bit_off = 16'(req.addr - ac_base);
                    else
                        rsp_nxt.error = 1'b1;
                    idx = bit_off[2:0];
                    if (!rsp_nxt.error)
                    begin
                        if (req.func == `FC_READ_COILS)
                            rsp_nxt.data = {15'h0000, out_byte_r[idx]};
                        else
                            out_byte_nxt[idx] = req.data[0] | req.data[8];
                        rsp_nxt.data = req.func == `FC_READ_COILS
                                     ? rsp_nxt.data : req.data;
                    end
                end
                `FC_READ_HOLD, `FC_WRITE_REG, `FC_WRITE_REGS:
                begin
                    if (req.addr != hr_base)
                        rsp_nxt.error = 1'b1;
                    else if (req.func == `FC_READ_HOLD)
                        rsp_nxt.data = {8'h00, out_byte_r};
                    else
                    begin
                        out_byte_nxt = req.data[7:0];
                        rsp_nxt.data = req.data;
                    end
                end
                default:
                    rsp_nxt.error = 1'b1;
            endcase
        end
        out_byte_nxt = out_byte_nxt & `OUT_CHAN_MASK;
    end

    // Exchange pacing and watchdog
    // An answer counts once both later sync stages agree high
    logic done_ev;
    assign done_ev = busy_r && (xd_r[2] == xd_r[1]) && xd_r[1];

    always_comb
    begin
        xchg_cnt_nxt = xchg_cnt_r + 20'h00001;
        busy_nxt     = busy_r;
        fail_cnt_nxt = fail_cnt_r;
        wd_cnt_nxt   = wd_cnt_r;
        trip_nxt     = trip_r;
        if (fail_cnt_r == `WDOG_FAIL_LIMIT && !trip_r)
        begin
            if (wd_cnt_r == 27'(WDOG_CYC - 1))
                trip_nxt = 1'b1;
            else
                wd_cnt_nxt = wd_cnt_r + 27'h0000001;
        end
        if (done_ev)
        begin
            busy_nxt = 1'b0;
            if (xchg_ok)
            begin
                fail_cnt_nxt = 2'd0;
                wd_cnt_nxt   = 27'h0000000;
                // A trip raised on this very edge still wins
                trip_nxt     = trip_nxt && !trip_r;
            end
            else if (fail_cnt_r != `WDOG_FAIL_LIMIT)
                fail_cnt_nxt = fail_cnt_r + 2'd1;
        end
        // A new period wins over an answer landing on the same edge
        if (xchg_cnt_r == 20'(XCHG_CYC - 1))
        begin
            xchg_cnt_nxt = 20'h00000;
            busy_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rsp_r      <= '0;
            out_byte_r <= 8'h00;
            xchg_cnt_r <= 20'h00000;
            fail_cnt_r <= 2'd0;
            wd_cnt_r   <= 27'h0000000;
            trip_r     <= 1'b0;
            busy_r     <= 1'b0;
            xd_r       <= 3'h0;
        end
        else
        begin
            rsp_r      <= rsp_nxt;
            out_byte_r <= out_byte_nxt;
            xchg_cnt_r <= xchg_cnt_nxt;
            fail_cnt_r <= fail_cnt_nxt;
            wd_cnt_r   <= wd_cnt_nxt;
            trip_r     <= trip_nxt;
            busy_r     <= busy_nxt;
            xd_r       <= {xd_r[1:0], xchg_done};
        end
    end

    assign rsp        = rsp_r;
    assign xchg_start = (xchg_cnt_r == 20'h00000) && !sys_rst;
    // no line fault input exists; nothing reports one
    assign relay_out  = trip_r ? 2'b00 : out_byte_r[1:0];
    assign wdog_trip  = trip_r;
endmodule
`default_nettype wire

// File: verification/com_unit_model.sv
// Purpose: Com unit answering each exchange request
// Assumes: ok_mode chosen by the bench
// Notes:   Done is held 5 cycles so the 3-stage sync sees it
`timescale 1ns/1ps
`default_nettype none
module com_unit_model (
    input wire logic ref_clk,
    input wire logic xchg_start,
    input wire logic ok_mode,
    output var logic xchg_done,
    output var logic xchg_ok
);
    logic [3:0] cnt = 4'h0;
    logic       busy;
    assign busy = cnt > 4'h1 && cnt < 4'h7;
    initial xchg_done = 1'b0;
    initial xchg_ok = 1'b0;
    always @(posedge ref_clk)
    begin
        cnt <= xchg_start ? 4'ha : cnt - {3'h0, cnt != 4'h0};
        xchg_done <= busy;
        // Status toggles outside the answer so a stale value never helps
        xchg_ok <= busy ? ok_mode : ~xchg_ok;
    end
endmodule
`default_nettype wire

// File: verification/relay_map_props.sv
// Purpose: Port checker for the relay output map
// Assumes: One clock, synchronous reset
// Notes:   Bound into every instance of the map
`timescale 1ns/1ps
`default_nettype none
`include "relay_map_params.svh"
module relay_map_props #(
    parameter int unsigned WDOG_CYC = 50
) (
    // Clock and reset
    input wire logic                ref_clk,
    input wire logic                sys_rst,
    // Master side
    input wire relay_map_pkg::req_t req,
    input wire relay_map_pkg::rsp_t rsp,
    input wire logic [7:0]          slot,
    // Com unit and relays
    input wire logic                xchg_start,
    input wire logic [1:0]          relay_out,
    input wire logic                wdog_trip
);
    localparam int XG = `XCHG_CYCLES;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence coil_on_s;
        req.valid && !req.alt && req.func == `FC_WRITE_COIL &&
        req.addr == `DIR_SLOT_COIL_BASE + {5'h00, slot, 3'h0} &&
        req.data == 16'hff00 && !wdog_trip;
    endsequence
    a_rsp_one_later: assert property (req.valid |=> rsp.valid)
        else $error("no answer one cycle after request");
    a_no_spur_rsp: assert property (!req.valid |=> !rsp.valid)
        else $error("answer without request");
    a_trip_off: assert property (wdog_trip |-> relay_out == 2'b00)
        else $error("relay driven while tripped");
    a_reset_clear: assert property ($fell(sys_rst) |->
        relay_out == 2'b00 && !wdog_trip)
        else $error("outputs not clear after reset");
    a_xchg_gap: assert property (xchg_start |=> !xchg_start [*8])
        else $error("exchange pulses too close");
    a_xchg_period: assert property (xchg_start |-> ##[XG:XG] xchg_start)
        else $error("exchange period wrong");
    a_bad_func: assert property (req.valid && !(req.func inside
        {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10})
        |=> rsp.valid && rsp.error)
        else $error("unknown code not refused");
    a_coil_on: assert property (coil_on_s |=> relay_out[0] || wdog_trip)
        else $error("slot coil write did not drive channel 1");
endmodule
bind relay_output_modbus_map relay_map_props #(.WDOG_CYC(WDOG_CYC)) i_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
    .slot(slot), .xchg_start(xchg_start), .relay_out(relay_out),
    .wdog_trip(wdog_trip));
`default_nettype wire

// File: verification/tb_relay_output_modbus_map.sv
// Purpose: Self-checking bench for the relay output map
// Assumes: Watchdog count shortened to 50 cycles
// Notes:   Master requests change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_relay_output_modbus_map;
    logic                ref_clk, sys_rst, ok_mode;
    relay_map_pkg::req_t req;
    relay_map_pkg::rsp_t rsp;
    logic                xchg_start, xchg_done, xchg_ok, wdog_trip;
    logic [1:0]          relay_out;
    int                  err_total, n_checks;
    relay_output_modbus_map #(.WDOG_CYC(50)) i_relay_output_modbus_map (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
        .slot(8'h03), .module_status(16'ha5c3), .module_type(16'h1234),
        .xchg_start(xchg_start), .xchg_done(xchg_done), .xchg_ok(xchg_ok),
        .relay_out(relay_out), .wdog_trip(wdog_trip));
    com_unit_model i_com_unit_model (.ref_clk(ref_clk), .ok_mode(ok_mode),
        .xchg_start(xchg_start), .xchg_done(xchg_done), .xchg_ok(xchg_ok));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic a, input logic [7:0] f,
                       input logic [15:0] ad, input logic [15:0] dt,
                       input logic er);
        @(negedge ref_clk);
        req = {1'b1, a, f, ad, dt};
        @(negedge ref_clk);
        req.valid = 1'b0;
        chk({14'h0, rsp.valid, rsp.error}, {14'h0, 1'b1, er});
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (6000) @(posedge ref_clk);
        err_total++;
        end_sim();
    end
    initial
    begin
        err_total = 0;
        n_checks = 0;
        ok_mode = 1'b1;
        req = '0;
        sys_rst = 1'b1;
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        acc(1'h0, 8'h05, 16'h0418, 16'hff00, 1'h0);
        chk({14'h0000, relay_out}, 16'h0001);
        acc(1'h1, 8'h0f, 16'h0bd2, 16'h0001, 1'h0);
        chk({14'h0000, relay_out}, 16'h0003);
        acc(1'h0, 8'h05, 16'h041b, 16'hff00, 1'h0);
        chk({14'h0000, relay_out}, 16'h0003);
        acc(1'h0, 8'h01, 16'h041b, 16'h0000, 1'h0);
        chk(rsp.data, 16'h0000);
        acc(1'h0, 8'h01, 16'h0419, 16'h0000, 1'h0);
        chk(rsp.data, 16'h0001);
        acc(1'h1, 8'h05, 16'h0001, 16'h0000, 1'h0);
        chk({14'h0000, relay_out}, 16'h0002);
        acc(1'h0, 8'h01, 16'h0001, 16'h0000, 1'h0);
        chk(rsp.data, 16'h0001);
        acc(1'h0, 8'h05, 16'h0000, 16'hff00, 1'h0);
        chk({14'h0000, relay_out}, 16'h0003);
        acc(1'h1, 8'h06, 16'hb415, 16'h00fd, 1'h0);
        chk({14'h0000, relay_out}, 16'h0001);
        acc(1'h0, 8'h03, 16'h0500, 16'h0000, 1'h0);
        chk(rsp.data, 16'h0001);
        acc(1'h0, 8'h10, 16'h0500, 16'h0002, 1'h0);
        chk({14'h0000, relay_out}, 16'h0002);
        acc(1'h1, 8'h03, 16'hb415, 16'h0000, 1'h0);
        chk(rsp.data, 16'h0002);
        acc(1'h0, 8'h03, 16'h0501, 16'h0000, 1'h1);
        acc(1'h0, 8'h06, 16'h0500, 16'h0001, 1'h0);
        chk({14'h0000, relay_out}, 16'h0001);
        $display("test coils done");
        acc(1'h0, 8'h04, 16'h0303, 16'h0000, 1'h0);
        chk(rsp.data, 16'ha5c3);
        acc(1'h1, 8'h04, 16'h8983, 16'h0000, 1'h0);
        chk(rsp.data, 16'ha5c3);
        acc(1'h1, 8'h04, 16'h89e7, 16'h0000, 1'h0);
        chk(rsp.data, 16'h1234);
        acc(1'h0, 8'h04, 16'h0403, 16'h0000, 1'h0);
        chk(rsp.data, 16'h1234);
        acc(1'h0, 8'h02, 16'h0818, 16'h0000, 1'h0);
        chk(rsp.data, 16'h0001);
        acc(1'h1, 8'h02, 16'h36ca, 16'h0000, 1'h0);
        chk(rsp.data, 16'h0000);
        acc(1'h0, 8'h02, 16'h041b, 16'h0000, 1'h1);
        acc(1'h0, 8'h07, 16'h0418, 16'h0000, 1'h1);
        acc(1'h0, 8'h04, 16'h7000, 16'h0000, 1'h1);
        acc(1'h0, 8'h05, 16'h0500, 16'h0000, 1'h1);
        chk({14'h0000, relay_out}, 16'h0001);
        $display("test words done");
        ok_mode = 1'h0;
        // Third failure lands 19.5 cycles before this look; trip not yet due
        repeat (2417) @(negedge ref_clk);
        chk({15'h0000, wdog_trip}, 16'h0000);
        chk({14'h0000, relay_out}, 16'h0001);
        repeat (99) @(negedge ref_clk);
        chk({15'h0000, wdog_trip}, 16'h0001);
        chk({14'h0000, relay_out}, 16'h0000);
        ok_mode = 1'h1;
        repeat (840) @(negedge ref_clk);
        chk({15'h0000, wdog_trip}, 16'h0000);
        chk({14'h0000, relay_out}, 16'h0001);
        $display("test watchdog done");
        sys_rst = 1'h1;
        repeat (2) @(negedge ref_clk);
        chk({14'h0000, relay_out}, 16'h0000);
        sys_rst = 1'h0;
        @(negedge ref_clk);
        chk({15'h0000, rsp.valid}, 16'h0000);
        acc(1'h0, 8'h05, 16'h0418, 16'hff00, 1'h0);
        chk({14'h0000, relay_out}, 16'h0001);
        $display("test reset done");
        end_sim();
    end
endmodule
`default_nettype wire
